// >>> src/itc_pkg.sv
// Package with register map, field layout and timing for the status and path control block
package itc_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_INTERRUPT_STATUS = 8'h08;
  localparam logic [7:0] OFF_RECEIVE_CONFIG   = 8'h0c;
  localparam logic [7:0] OFF_TRANSMIT_CONFIG  = 8'h10;

  // Status field positions
  localparam int BIT_MAC_RESET_TIMEOUT = 18;
  localparam int BIT_TX_STOPPED        = 17;
  localparam int BIT_RX_STOPPED        = 16;
  localparam int BIT_PHY_EVENT         = 15;
  localparam int BIT_TX_ERROR          = 14;
  localparam int BIT_TX_UNDERRUN       = 13;
  localparam int BIT_TX_OVERRUN        = 12;
  localparam int BIT_RX_DROPPED        = 11;
  localparam int PIN_COUNT             = 11;

  // Config field positions
  localparam int BIT_RX_FLUSH  = 0;
  localparam int BIT_TX_FLUSH  = 0;
  localparam int BIT_TX_STOP   = 1;
  localparam int BIT_TX_ENABLE = 2;

  // Reset values
  localparam logic [31:0] RESET_RECEIVE_CONFIG  = 32'h0000_0000;
  localparam logic [31:0] RESET_TRANSMIT_CONFIG = 32'h0000_0000;

  // Watchdog timing: 8 ms at 100 MHz
  localparam int CLK_MHZ             = 100;
  localparam int WATCHDOG_MS         = 8;
  localparam int WATCHDOG_CYCLES     = WATCHDOG_MS * 1000 * CLK_MHZ;

  // Pulse events from the MAC and data path
  typedef struct packed {
    logic tx_halted;
    logic rx_halted;
    logic tx_error;
    logic tx_underrun;
    logic tx_overrun;
    logic rx_dropped;
  } itc_event_type;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } itc_bus_type;

endpackage

// >>> src/itc_top.sv
// Interrupt status and transmit/receive path control register bank
// Overview of operation
// - Watchdog expiry of 8 ms sets bit 18
// - Watchdog expiry releases MAC reset on the next clk edge
// - Bit 17 set when stop requested and halted
// - Bit 16 set when receiver halts
// - Bit 15 mirrors PHY level interrupt, read-only
// - Bit 14 set on transmitter error pulse
// - Bit 13 set on TX FIFO underrun
// - Bit 12 set on write to full FIFO
// - Bit 11 set on dropped receive frame
// - Bits 10:0 report pin level interrupts
// - Clearing pin bit clears its wake event
// - Write one clears, zero leaves unchanged
// - RX config bit 0 flushes RX pointers, self-clears
// - TX config bit 0 flushes TX pointers, self-clears
// - TX config bit 2 enables the transmitter
// - Enable auto-clears when stopped and halted
// - Stop bit halts after frame, then self-clears
// - Writes to stop bit ignored while high
// - No frame data remains after stop clears
// - Self-clearing bits clear, ignore zeros, readable
`timescale 1ns/1ps
module itc_top #(
  parameter int WATCHDOG_CYCLES = itc_pkg::WATCHDOG_CYCLES,
  parameter int PIN_COUNT       = itc_pkg::PIN_COUNT
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Register port
  input  wire itc_pkg::itc_bus_type   bus,
  output logic [31:0]                 rdata,
  // Events from MAC and FIFOs (same clock)
  input  wire itc_pkg::itc_event_type evt,
  input  wire logic                   tx_frame_active,
  input  wire logic                   tx_path_empty,
  input  wire logic                   mac_clock_seen,
  // Asynchronous level inputs
  input  wire logic                   phy_irq_level,
  input  wire logic [PIN_COUNT-1:0]   pin_level,
  // Control outputs
  output logic                        rx_flush,
  output logic                        tx_flush,
  output logic                        tx_enable,
  output logic                        tx_stop_req,
  output logic                        mac_reset_n,
  output logic [PIN_COUNT-1:0]        wake_clear
);

  // Synchroniser first stage for the PHY and pin levels
  logic [PIN_COUNT:0]         sync1_reg;
  wire  logic [PIN_COUNT:0]   sync1_next = {phy_irq_level, pin_level};
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
    end
  end

  // Synchroniser second stage; nothing else reads the first stage
  logic [PIN_COUNT:0]         sync2_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync2_reg <= '0;
    end else begin
      sync2_reg <= sync1_reg;
    end
  end

  // Synchronised PHY and pin levels
  wire  logic                 phy_level_s = sync2_reg[PIN_COUNT];
  wire  logic [PIN_COUNT-1:0] pin_level_s = sync2_reg[PIN_COUNT-1:0];

  // Register select
  wire  logic                 hit_sts = (bus.addr == itc_pkg::OFF_INTERRUPT_STATUS);
  wire  logic                 hit_rx  = (bus.addr == itc_pkg::OFF_RECEIVE_CONFIG);
  wire  logic                 hit_tx  = (bus.addr == itc_pkg::OFF_TRANSMIT_CONFIG);

  // Write strobes per register; unmapped writes are dropped
  wire  logic                 wr_sts = bus.wr && hit_sts;
  wire  logic                 wr_rx  = bus.wr && hit_rx;
  wire  logic                 wr_tx  = bus.wr && hit_tx;

  // Write-one-to-clear mask, zero bits leave the flags alone
  wire  logic [31:0]          clr = wr_sts ? bus.wdata : 32'h0000_0000;

  // Clear request per pulse-sourced status flag
  wire  logic clr_mac_timeout = clr[itc_pkg::BIT_MAC_RESET_TIMEOUT];
  wire  logic clr_tx_stopped  = clr[itc_pkg::BIT_TX_STOPPED];
  wire  logic clr_rx_stopped  = clr[itc_pkg::BIT_RX_STOPPED];
  wire  logic clr_tx_error    = clr[itc_pkg::BIT_TX_ERROR];
  wire  logic clr_tx_underrun = clr[itc_pkg::BIT_TX_UNDERRUN];
  wire  logic clr_tx_overrun  = clr[itc_pkg::BIT_TX_OVERRUN];
  wire  logic clr_rx_dropped  = clr[itc_pkg::BIT_RX_DROPPED];

  // Watchdog limit: the count at which the MAC clocks are declared missing
  logic [31:0]                wd_cnt_reg;
  logic                       wd_expired_reg;
  wire  logic                 wd_at_limit = (wd_cnt_reg == 32'(WATCHDOG_CYCLES - 1));
  wire  logic                 wd_hit = !wd_expired_reg && !mac_clock_seen && wd_at_limit;

  // Watchdog next state: restart on MAC clock activity, freeze once expired
  wire  logic [31:0]          wd_cnt_run  = 32'(wd_cnt_reg + 32'h0000_0001);
  wire  logic [31:0]          wd_cnt_next = mac_clock_seen ? 32'h0000_0000 :
                                            wd_expired_reg ? wd_cnt_reg : wd_cnt_run;
  wire  logic                 wd_expired_next = wd_expired_reg || wd_hit;

  // Watchdog counter
  always_ff @(posedge clk) begin
    if (rst) begin
      wd_cnt_reg <= 32'h0000_0000;
    end else begin
      wd_cnt_reg <= wd_cnt_next;
    end
  end

  // Watchdog expiry latch; it never re-arms until reset
  always_ff @(posedge clk) begin
    if (rst) begin
      wd_expired_reg <= 1'b0;
    end else begin
      wd_expired_reg <= wd_expired_next;
    end
  end

  // MAC reset release: clock activity or watchdog expiry, held until reset
  logic                       mac_reset_n_reg;
  wire  logic mac_reset_n_next = mac_reset_n_reg || mac_clock_seen || wd_hit;

  // MAC reset register; the release does not wait for any MAC clock edge
  always_ff @(posedge clk) begin
    if (rst) begin
      mac_reset_n_reg <= 1'b0;
    end else begin
      mac_reset_n_reg <= mac_reset_n_next;
    end
  end

  // Flush requests, one cycle each, so they read back as zero
  logic                       rx_flush_reg;
  logic                       tx_flush_reg;
  wire  logic rx_flush_next = wr_rx && bus.wdata[itc_pkg::BIT_RX_FLUSH];
  wire  logic tx_flush_next = wr_tx && bus.wdata[itc_pkg::BIT_TX_FLUSH];

  // Receive flush strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_flush_reg <= itc_pkg::RESET_RECEIVE_CONFIG[itc_pkg::BIT_RX_FLUSH];
    end else begin
      rx_flush_reg <= rx_flush_next;
    end
  end

  // Transmit flush strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_flush_reg <= itc_pkg::RESET_TRANSMIT_CONFIG[itc_pkg::BIT_TX_FLUSH];
    end else begin
      tx_flush_reg <= tx_flush_next;
    end
  end

  // Transmitter halt taken: stop pending, halt pulse, frame done, path drained
  logic                       tx_enable_reg;
  logic                       tx_stop_reg;
  wire  logic tx_halted_ok = tx_stop_reg && evt.tx_halted && !tx_frame_active &&
                             tx_path_empty;

  // Transmit control write fields
  wire  logic stop_write_one = wr_tx && bus.wdata[itc_pkg::BIT_TX_STOP];
  wire  logic enable_write   = bus.wdata[itc_pkg::BIT_TX_ENABLE];

  // Enable: follows software, dropped by hardware when the stop completes
  wire  logic tx_enable_next = tx_halted_ok ? 1'b0 :
                               wr_tx        ? enable_write : tx_enable_reg;

  // Stop: a one written while low starts it, any write while high is ignored
  wire  logic tx_stop_next = tx_halted_ok ? 1'b0 :
                             (tx_stop_reg || stop_write_one);

  // Transmitter enable register
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_enable_reg <= itc_pkg::RESET_TRANSMIT_CONFIG[itc_pkg::BIT_TX_ENABLE];
    end else begin
      tx_enable_reg <= tx_enable_next;
    end
  end

  // Stop request register
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_stop_reg <= itc_pkg::RESET_TRANSMIT_CONFIG[itc_pkg::BIT_TX_STOP];
    end else begin
      tx_stop_reg <= tx_stop_next;
    end
  end

  // Set conditions of the pulse-sourced flags
  wire  logic set_mac_timeout = wd_hit;
  wire  logic set_tx_stopped  = tx_halted_ok;
  wire  logic set_rx_stopped  = evt.rx_halted;
  wire  logic set_tx_error    = evt.tx_error;
  wire  logic set_tx_underrun = evt.tx_underrun;
  wire  logic set_tx_overrun  = evt.tx_overrun;
  wire  logic set_rx_dropped  = evt.rx_dropped;

  // Flag registers
  logic                       mac_reset_timeout_flag_reg;
  logic                       transmitter_stopped_flag_reg;
  logic                       receiver_stopped_flag_reg;
  logic                       transmit_error_flag_reg;
  logic                       tx_fifo_underrun_flag_reg;
  logic                       tx_fifo_overrun_flag_reg;
  logic                       rx_frame_dropped_flag_reg;

  // Flag next values: a new event wins over a same-cycle clear
  wire  logic mac_reset_timeout_flag_next   = set_mac_timeout |
                                              (mac_reset_timeout_flag_reg & ~clr_mac_timeout);
  wire  logic transmitter_stopped_flag_next = set_tx_stopped |
                                              (transmitter_stopped_flag_reg & ~clr_tx_stopped);
  wire  logic receiver_stopped_flag_next    = set_rx_stopped |
                                              (receiver_stopped_flag_reg & ~clr_rx_stopped);
  wire  logic transmit_error_flag_next      = set_tx_error |
                                              (transmit_error_flag_reg & ~clr_tx_error);
  wire  logic tx_fifo_underrun_flag_next    = set_tx_underrun |
                                              (tx_fifo_underrun_flag_reg & ~clr_tx_underrun);
  wire  logic tx_fifo_overrun_flag_next     = set_tx_overrun |
                                              (tx_fifo_overrun_flag_reg & ~clr_tx_overrun);
  wire  logic rx_frame_dropped_flag_next    = set_rx_dropped |
                                              (rx_frame_dropped_flag_reg & ~clr_rx_dropped);

  // MAC reset timeout flag
  always_ff @(posedge clk) begin
    if (rst) begin
      mac_reset_timeout_flag_reg <= 1'b0;
    end else begin
      mac_reset_timeout_flag_reg <= mac_reset_timeout_flag_next;
    end
  end

  // Transmitter stopped flag
  always_ff @(posedge clk) begin
    if (rst) begin
      transmitter_stopped_flag_reg <= 1'b0;
    end else begin
      transmitter_stopped_flag_reg <= transmitter_stopped_flag_next;
    end
  end

  // Receiver stopped flag
  always_ff @(posedge clk) begin
    if (rst) begin
      receiver_stopped_flag_reg <= 1'b0;
    end else begin
      receiver_stopped_flag_reg <= receiver_stopped_flag_next;
    end
  end

  // Transmit error flag
  always_ff @(posedge clk) begin
    if (rst) begin
      transmit_error_flag_reg <= 1'b0;
    end else begin
      transmit_error_flag_reg <= transmit_error_flag_next;
    end
  end

  // Transmit FIFO underrun flag
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_fifo_underrun_flag_reg <= 1'b0;
    end else begin
      tx_fifo_underrun_flag_reg <= tx_fifo_underrun_flag_next;
    end
  end

  // Transmit FIFO overrun flag, a sign of a broken data path
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_fifo_overrun_flag_reg <= 1'b0;
    end else begin
      tx_fifo_overrun_flag_reg <= tx_fifo_overrun_flag_next;
    end
  end

  // Receive frame dropped flag
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_frame_dropped_flag_reg <= 1'b0;
    end else begin
      rx_frame_dropped_flag_reg <= rx_frame_dropped_flag_next;
    end
  end

  // Pin flags and wake clears
  logic [PIN_COUNT-1:0]       pin_event_flags_reg;
  logic [PIN_COUNT-1:0]       pin_event_flags_next;
  logic [PIN_COUNT-1:0]       wake_clear_reg;
  logic [PIN_COUNT-1:0]       wake_clear_next;

  // Per pin: a high level sets the flag and beats a clear; a clear drops the wake event
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      assign pin_event_flags_next[g] = pin_level_s[g] | (pin_event_flags_reg[g] & ~clr[g]);
      assign wake_clear_next[g]      = clr[g];
    end
  endgenerate

  // Pin flag register; after reset it latches high synchronised pin levels until cleared
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_event_flags_reg <= '0;
    end else begin
      pin_event_flags_reg <= pin_event_flags_next;
    end
  end

  // Wake clear pulses, one cycle after the clearing write
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_clear_reg <= '0;
    end else begin
      wake_clear_reg <= wake_clear_next;
    end
  end

  // Status word assembly; the PHY bit is a plain mirror with no storage
  logic [31:0]                sts_word;
  always_comb begin
    sts_word = 32'h0000_0000;
    sts_word[itc_pkg::BIT_MAC_RESET_TIMEOUT] = mac_reset_timeout_flag_reg;
    sts_word[itc_pkg::BIT_TX_STOPPED]        = transmitter_stopped_flag_reg;
    sts_word[itc_pkg::BIT_RX_STOPPED]        = receiver_stopped_flag_reg;
    sts_word[itc_pkg::BIT_PHY_EVENT]         = phy_level_s;
    sts_word[itc_pkg::BIT_TX_ERROR]          = transmit_error_flag_reg;
    sts_word[itc_pkg::BIT_TX_UNDERRUN]       = tx_fifo_underrun_flag_reg;
    sts_word[itc_pkg::BIT_TX_OVERRUN]        = tx_fifo_overrun_flag_reg;
    sts_word[itc_pkg::BIT_RX_DROPPED]        = rx_frame_dropped_flag_reg;
    sts_word[PIN_COUNT-1:0]                  = pin_event_flags_reg;
  end

  // Receive configuration word
  logic [31:0]                rx_word;
  always_comb begin
    rx_word = 32'h0000_0000;
    rx_word[itc_pkg::BIT_RX_FLUSH] = rx_flush_reg;
  end

  // Transmit configuration word
  logic [31:0]                tx_word;
  always_comb begin
    tx_word = 32'h0000_0000;
    tx_word[itc_pkg::BIT_TX_FLUSH]  = tx_flush_reg;
    tx_word[itc_pkg::BIT_TX_STOP]   = tx_stop_reg;
    tx_word[itc_pkg::BIT_TX_ENABLE] = tx_enable_reg;
  end

  // Read select; unmapped addresses read as zero
  wire  logic [31:0] rd_mux = hit_sts ? sts_word :
                              hit_rx  ? rx_word  :
                              hit_tx  ? tx_word  : 32'h0000_0000;
  wire  logic [31:0] rdata_next = bus.rd ? rd_mux : 32'h0000_0000;

  // Read data register, valid the cycle after the read strobe only
  logic [31:0]                rdata_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flops
  assign rdata       = rdata_reg;
  assign rx_flush    = rx_flush_reg;
  assign tx_flush    = tx_flush_reg;
  assign tx_enable   = tx_enable_reg;
  assign tx_stop_req = tx_stop_reg;
  assign mac_reset_n = mac_reset_n_reg;
  assign wake_clear  = wake_clear_reg;

endmodule // itc_top

// >>> sim/itc_monitor.sv
// Checker for the status and path control register bank
`timescale 1ns/1ps
module itc_monitor #(
  parameter int WATCHDOG_CYCLES = 20,
  parameter int PIN_COUNT = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port and far side
  input wire itc_pkg::itc_bus_type bus,
  input wire itc_pkg::itc_event_type evt,
  input wire logic tx_frame_active,
  input wire logic tx_path_empty,
  input wire logic mac_clock_seen,
  // Control outputs
  input wire logic rx_flush,
  input wire logic tx_flush,
  input wire logic tx_enable,
  input wire logic tx_stop_req,
  input wire logic mac_reset_n,
  input wire logic [PIN_COUNT-1:0] wake_clear
);
  int wd_cnt;
  wire halt = tx_stop_req && evt.tx_halted && !tx_frame_active && tx_path_empty;
  wire tx_wr = bus.wr && bus.addr == 8'h10;
  wire rx_set = bus.wr && bus.addr == 8'h0c && bus.wdata[0];
  wire tx_set = tx_wr && bus.wdata[0];
  // Cycles without MAC clock activity since reset or the last MAC clock activity
  always_ff @(posedge clk) begin
    if (rst || mac_clock_seen) wd_cnt <= 0;
    else wd_cnt <= wd_cnt + 1;
  end
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RXF: assert property (bus.wr && bus.addr == 8'h0c && bus.wdata[0] |=> rx_flush)
    else $error("rx flush missing");
  AST_SCL: assert property (rx_flush && !rx_set |=> !rx_flush)
    else $error("rx flush stuck");
  AST_SCT: assert property (tx_flush && !tx_set |=> !tx_flush)
    else $error("tx flush stuck");
  AST_TXF: assert property (tx_wr && bus.wdata[0] |=> tx_flush)
    else $error("tx flush missing");
  AST_TEN: assert property (tx_wr && !halt |=> tx_enable == $past(bus.wdata[2]))
    else $error("tx enable wrong");
  AST_AUT: assert property (halt |=> !tx_enable && !tx_stop_req)
    else $error("halt not taken");
  AST_IGN: assert property (tx_stop_req && !halt |=> tx_stop_req)
    else $error("stop dropped");
  AST_EMP: assert property ($fell(tx_stop_req) |-> $past(tx_path_empty))
    else $error("path not empty");
  AST_WDG: assert property (wd_cnt >= WATCHDOG_CYCLES + 3 |-> mac_reset_n)
    else $error("mac reset held");
  AST_WAK: assert property (bus.wr && bus.addr == 8'h08
    |=> wake_clear == $past(bus.wdata[PIN_COUNT-1:0]))
    else $error("wake clear wrong");
endmodule // itc_monitor
bind itc_top itc_monitor #(.WATCHDOG_CYCLES(WATCHDOG_CYCLES), .PIN_COUNT(PIN_COUNT))
  itc_monitor_inst (.clk(clk), .rst(rst), .bus(bus), .evt(evt),
  .tx_frame_active(tx_frame_active), .tx_path_empty(tx_path_empty),
  .mac_clock_seen(mac_clock_seen), .rx_flush(rx_flush), .tx_flush(tx_flush),
  .tx_enable(tx_enable), .tx_stop_req(tx_stop_req), .mac_reset_n(mac_reset_n),
  .wake_clear(wake_clear));

// >>> sim/itc_mac_model.sv
// Far side model: transmitter that finishes its frame before halting
`timescale 1ns/1ps
module itc_mac_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Stop request and injected events
  input wire logic tx_stop_req,
  input wire itc_pkg::itc_event_type inj,
  // Towards the block
  output itc_pkg::itc_event_type evt,
  output logic tx_frame_active,
  output logic tx_path_empty
);
  logic [3:0] left_reg;
  // Count down the rest of the frame once a stop is requested
  always_ff @(posedge clk) begin
    if (rst || !tx_stop_req) left_reg <= 4'h5;
    else if (left_reg != 4'h0) left_reg <= left_reg - 4'h1;
  end
  // Frame drains, then path empties with one halt pulse in that same cycle
  assign tx_frame_active = tx_stop_req && left_reg > 4'h2;
  assign tx_path_empty = !tx_stop_req || left_reg < 4'h2;
  always_comb begin
    evt = inj;
    evt.tx_halted = inj.tx_halted || (tx_stop_req && left_reg == 4'h1);
  end
endmodule // itc_mac_model

// >>> sim/itc_top_test.sv
// Testbench for the status and path control register bank
`timescale 1ns/1ps
module itc_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic seen = 1'b0;
  logic phy = 1'b0;
  logic [10:0] pins = 11'h000;
  itc_pkg::itc_bus_type bus = '0;
  itc_pkg::itc_event_type inj = '0;
  itc_pkg::itc_event_type evt;
  logic act, emp, rxf, txf, ten, tsr, mrn;
  logic [31:0] rdata;
  int mismatches = 0;
  int total_checks = 0;
  int sb [5] = '{11, 12, 13, 14, 16};
  // Clock
  always #5 clk = ~clk;
  // Design and far side
  itc_top #(.WATCHDOG_CYCLES(20)) itc_top_inst (.clk(clk), .rst(rst), .bus(bus),
    .rdata(rdata), .evt(evt), .tx_frame_active(act), .tx_path_empty(emp),
    .mac_clock_seen(seen), .phy_irq_level(phy), .pin_level(pins), .rx_flush(rxf),
    .tx_flush(txf), .tx_enable(ten), .tx_stop_req(tsr), .mac_reset_n(mrn), .wake_clear());
  itc_mac_model itc_mac_model_inst (.clk(clk), .rst(rst), .tx_stop_req(tsr), .inj(inj),
    .evt(evt), .tx_frame_active(act), .tx_path_empty(emp));
  // Compare and report
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Register write, optionally with an event pulse in the same cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input itc_pkg::itc_event_type e);
    inj <= e;
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    inj <= '0;
    bus <= '0;
    @(posedge clk);
  endtask
  // Register read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk($sformatf("reg %h", a), rdata, e);
    @(posedge clk);
  endtask
  // Verdict
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    complete_run;
  end
  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    chk("mac_reset_n", {31'h0, mrn}, 32'h0);
    repeat (30) @(posedge clk);
    chk("mac_reset_n", {31'h0, mrn}, 32'h1);
    rd(8'h08, 32'h40000);
    wr(8'h08, 32'h0, '0);
    rd(8'h08, 32'h40000);
    wr(8'h08, 32'h40000, '0);
    rd(8'h08, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(8'hfc, 32'hffff_ffff, 6'(1 << i));
      rd(8'h08, i == 5 ? 32'h0 : 32'h1 << sb[i]);
      wr(8'h08, 32'hffff_ffff, '0);
    end
    wr(8'h08, 32'h800, 6'h01);
    rd(8'h08, 32'h800);
    phy <= 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h08, 32'h8800, '0);
    rd(8'h08, 32'h8000);
    phy <= 1'b0;
    pins <= 11'h401;
    repeat (4) @(posedge clk);
    rd(8'h08, 32'h401);
    pins <= 11'h000;
    repeat (4) @(posedge clk);
    wr(8'h08, 32'h7ff, '0);
    rd(8'h08, 32'h0);
    wr(8'h0c, 32'h1, '0);
    rd(8'h0c, 32'h0);
    wr(8'h10, 32'h1, '0);
    rd(8'h10, 32'h0);
    wr(8'h10, 32'h4, '0);
    rd(8'h10, 32'h4);
    wr(8'h10, 32'h6, '0);
    wr(8'h10, 32'h4, '0);
    rd(8'h10, 32'h6);
    repeat (4) @(posedge clk);
    rd(8'h10, 32'h0);
    rd(8'h08, 32'h20000);
    rst <= 1'b1;
    seen <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("mac_reset_n", {31'h0, mrn}, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("mac_reset_n", {31'h0, mrn}, 32'h1);
    @(posedge clk);
    rd(8'h08, 32'h0);
    repeat (30) @(posedge clk);
    rd(8'h08, 32'h0);
    complete_run;
  end
endmodule // itc_top_test
